// [pkg/itb_cfg.svh]
`ifndef ITB_CFG_SVH
`define ITB_CFG_SVH

// Register byte offsets on the APB window.
`define ITB_ADDR_W          12
`define ITB_OFS_MODE        12'h000
`define ITB_OFS_COUNT       12'h004
`define ITB_OFS_SRCSEL      12'h008
`define ITB_OFS_CTRL        12'h00C

// Reset values, and the count value that overflows.
`define ITB_MODE_RST        8'h10
`define ITB_SRCSEL_RST      8'hFE
`define ITB_CTRL_RST        8'h01
`define ITB_COUNT_RST       8'h00
`define ITB_COUNT_MAX       8'hFF

// Mode register fields, and the select register bits that read as one.
`define ITB_MODE_OUT_MSB    7
`define ITB_MODE_OUT_LSB    5
`define ITB_MODE_RSVD       4
`define ITB_MODE_TBS        3
`define ITB_MODE_CLR        2
`define ITB_MODE_SEL_MSB    2
`define ITB_MODE_RSVD_MASK  8'h10
`define ITB_SRCSEL_ONES     8'hFE

// Control register fields.
`define ITB_CTRL_RUN        0
`define ITB_CTRL_OUTEN      1
`define ITB_CTRL_IEN        2
`define ITB_CTRL_FLAG       3

// Prescaler widths and tap bits (tap k toggles every 2**k steps).
`define ITB_SYS_W           13
`define ITB_SUB_W           7
`define ITB_SYS_TAP_8192    4'hC
`define ITB_SYS_TAP_2048    4'hA
`define ITB_SYS_TAP_512     4'h8
`define ITB_SYS_TAP_256     4'h7
`define ITB_SYS_TAP_32      4'h4
`define ITB_SUB_TAP_1S      3'h6
`define ITB_SUB_TAP_HALF    3'h5
`define ITB_SUB_TAP_QUART   3'h4
`define ITB_SUB_TAP_32ND    3'h1
`define ITB_OUT_TAP_DIV32   3'd4
`define ITB_OUT_TAP_DIV16   3'd3
`define ITB_OUT_TAP_DIV8    3'd2
`define ITB_OUT_TAP_DIV4    3'd1

`endif

// [pkg/itb_pkg.sv]
`default_nettype none

package itb_pkg;

    // Power state of the surrounding chip, driven by the power manager.
    typedef enum logic [2:0] {
        ITB_ACTIVE,
        ITB_SLEEP,
        ITB_WATCH,
        ITB_SUBACTIVE,
        ITB_SUBSLEEP,
        ITB_STANDBY
    } itb_pwr_t;

endpackage : itb_pkg

`default_nettype wire

// [core/itb_prescaler.sv]
`default_nettype none

module itb_prescaler
    import itb_pkg::*;
#(
    parameter int WIDTH = 13
)
(
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             clear,
    input  wire logic             step,
    output var  logic [WIDTH-1:0] count
);

    always_ff @(posedge sys_clk)
    begin
        if (srst || clear)
            count <= '0;
        else if (step)
            count <= count + 1'b1;
    end

endmodule // itb_prescaler

`default_nettype wire

// [core/itb_timer.sv]

`include "itb_cfg.svh"

`default_nettype none

module itb_timer
    import itb_pkg::*;
#(
    parameter logic [3:0] SYS_TAP_SEL1 = 4'hB,
    parameter logic [3:0] SYS_TAP_SEL5 = 4'h6,
    parameter logic [3:0] SYS_TAP_SEL7 = 4'h2
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`ITB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   subclock,
    input  wire itb_pwr_t               power_mode,
    output var  logic                   clock_output_pin,
    output var  logic                   overflow_irq
);

    ////////////////////////////////////////////////////////////////////////

    logic [7:0]            timer_mode_register_r;
    logic                  raw_sel_r;
    logic                  module_run_bit_r;
    logic                  clk_out_enable_r;
    logic                  overflow_irq_enable_r;
    logic                  overflow_request_flag_r;
    logic [7:0]            count_value_r;
    logic [31:0]           rdata_r;
    logic [31:0]           rdata_nxt;
    logic                  sub_s1_r;
    logic                  sub_s2_r;
    logic                  sub_s3_r;
    logic                  tap_d_r;
    logic                  pin_r;
    logic [`ITB_SYS_W-1:0] sys_cnt;
    logic [`ITB_SUB_W-1:0] sub_cnt;
    logic [3:0]            sys_tap;
    logic [2:0]            sub_tap;
    logic [2:0]            out_tap;
    logic                  time_base;
    logic                  base_clear;
    logic                  sub_rise;
    logic                  psw_step;
    logic                  tap_level;
    logic                  tick;
    logic                  count_en;
    logic                  overflow;
    logic                  full_power;
    logic                  selected_clock;
    logic                  setup;
    logic                  wr_access;
    logic                  mapped;

    assign time_base  = timer_mode_register_r[`ITB_MODE_TBS];
    assign base_clear = time_base && timer_mode_register_r[`ITB_MODE_CLR];
    assign full_power = (power_mode == ITB_ACTIVE)
                      || (power_mode == ITB_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data registered in the setup cycle.

    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign mapped    = (paddr == `ITB_OFS_MODE) || (paddr == `ITB_OFS_COUNT)
                     || (paddr == `ITB_OFS_SRCSEL) || (paddr == `ITB_OFS_CTRL);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign prdata    = rdata_r;

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `ITB_OFS_MODE:
                rdata_nxt[7:0] = timer_mode_register_r;
            `ITB_OFS_COUNT:
                rdata_nxt[7:0] = (power_mode == ITB_SUBACTIVE)
                               ? 8'h00 : count_value_r;
            `ITB_OFS_SRCSEL:
                rdata_nxt[7:0] = `ITB_SRCSEL_ONES | {7'h00, raw_sel_r};
            `ITB_OFS_CTRL:
            begin
                rdata_nxt[`ITB_CTRL_RUN]   = module_run_bit_r;
                rdata_nxt[`ITB_CTRL_OUTEN] = clk_out_enable_r;
                rdata_nxt[`ITB_CTRL_IEN]   = overflow_irq_enable_r;
                rdata_nxt[`ITB_CTRL_FLAG]  = overflow_request_flag_r;
            end
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata_r <= 32'h0000_0000;
        else if (setup)
            rdata_r <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register.

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            timer_mode_register_r <= `ITB_MODE_RST;
        else if (wr_access && paddr == `ITB_OFS_MODE)
        begin
            timer_mode_register_r[`ITB_MODE_OUT_MSB:`ITB_MODE_OUT_LSB]
                <= pwdata[`ITB_MODE_OUT_MSB:`ITB_MODE_OUT_LSB];
            timer_mode_register_r[`ITB_MODE_SEL_MSB:0]
                <= pwdata[`ITB_MODE_SEL_MSB:0];
            if (module_run_bit_r)
                timer_mode_register_r[`ITB_MODE_TBS]
                    <= pwdata[`ITB_MODE_TBS];
        end
        else
            timer_mode_register_r[`ITB_MODE_RSVD] <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output source select and control registers.

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            raw_sel_r <= 1'(`ITB_SRCSEL_RST);
        else if (wr_access && paddr == `ITB_OFS_SRCSEL)
            raw_sel_r <= pwdata[0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            module_run_bit_r      <= 1'(`ITB_CTRL_RST);
            clk_out_enable_r      <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
        end
        else if (wr_access && paddr == `ITB_OFS_CTRL)
        begin
            module_run_bit_r      <= pwdata[`ITB_CTRL_RUN];
            clk_out_enable_r      <= pwdata[`ITB_CTRL_OUTEN];
            overflow_irq_enable_r <= pwdata[`ITB_CTRL_IEN];
        end
    end

    // Writing one to the flag bit clears it; a same-cycle overflow wins.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            overflow_request_flag_r <= 1'b0;
        else if (overflow)
            overflow_request_flag_r <= 1'b1;
        else if (wr_access && paddr == `ITB_OFS_CTRL
                 && pwdata[`ITB_CTRL_FLAG])
            overflow_request_flag_r <= 1'b0;
    end

    assign overflow_irq = overflow_request_flag_r && overflow_irq_enable_r;

    ////////////////////////////////////////////////////////////////////////
    // Subclock synchroniser; the second and third stages feed the edge detector, the second also the raw output path.

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end
        else
        begin
            sub_s1_r <= subclock;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end

    assign sub_rise = sub_s2_r && !sub_s3_r;
    assign psw_step = sub_rise && module_run_bit_r
                   && (power_mode != ITB_STANDBY);

    ////////////////////////////////////////////////////////////////////////
    // Prescalers.

    itb_prescaler #(
        .WIDTH (`ITB_SYS_W)
    ) u_system_prescaler (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clear   (1'b0),
        .step    (1'b1),
        .count   (sys_cnt)
    );

    itb_prescaler #(
        .WIDTH (`ITB_SUB_W)
    ) u_subclock_prescaler (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clear   (base_clear),
        .step    (psw_step),
        .count   (sub_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Count clock selection.

    always_comb
    begin
        case (timer_mode_register_r[`ITB_MODE_SEL_MSB:0])
            3'h0:    sys_tap = `ITB_SYS_TAP_8192;
            3'h1:    sys_tap = SYS_TAP_SEL1;
            3'h2:    sys_tap = `ITB_SYS_TAP_2048;
            3'h3:    sys_tap = `ITB_SYS_TAP_512;
            3'h4:    sys_tap = `ITB_SYS_TAP_256;
            3'h5:    sys_tap = SYS_TAP_SEL5;
            3'h6:    sys_tap = `ITB_SYS_TAP_32;
            3'h7:    sys_tap = SYS_TAP_SEL7;
            default: sys_tap = `ITB_SYS_TAP_8192;
        endcase
        case (timer_mode_register_r[1:0])
            2'h0:    sub_tap = `ITB_SUB_TAP_1S;
            2'h1:    sub_tap = `ITB_SUB_TAP_HALF;
            2'h2:    sub_tap = `ITB_SUB_TAP_QUART;
            2'h3:    sub_tap = `ITB_SUB_TAP_32ND;
            default: sub_tap = `ITB_SUB_TAP_1S;
        endcase
    end

    assign tap_level = time_base ? sub_cnt[sub_tap] : sys_cnt[sys_tap];

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            tap_d_r <= 1'b0;
        else
            tap_d_r <= tap_level;
    end

    assign tick = tap_level && !tap_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Counter.

    assign count_en = module_run_bit_r
                   && (time_base ? (power_mode != ITB_STANDBY) : full_power);

    assign overflow = count_en && tick && !base_clear
                   && (count_value_r == `ITB_COUNT_MAX);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            count_value_r <= `ITB_COUNT_RST;
        else if (base_clear)
            count_value_r <= `ITB_COUNT_RST;
        else if (count_en && tick)
            count_value_r <= count_value_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock output. Switching source mid-period may leave one short pulse.

    always_comb
    begin
        case (timer_mode_register_r[6:5])
            2'h0:    out_tap = `ITB_OUT_TAP_DIV32;
            2'h1:    out_tap = `ITB_OUT_TAP_DIV16;
            2'h2:    out_tap = `ITB_OUT_TAP_DIV8;
            2'h3:    out_tap = `ITB_OUT_TAP_DIV4;
            default: out_tap = `ITB_OUT_TAP_DIV32;
        endcase
        if (raw_sel_r)
            selected_clock = sub_s2_r;
        else if (timer_mode_register_r[`ITB_MODE_OUT_MSB])
            selected_clock = sub_cnt[out_tap]
                          && (power_mode != ITB_STANDBY);
        else
            selected_clock = sys_cnt[out_tap] && full_power;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            pin_r <= 1'b0;
        else
            pin_r <= clk_out_enable_r && selected_clock;
    end

    assign clock_output_pin = pin_r;

endmodule // itb_timer

`default_nettype wire

// [test/itb_timer_properties.sv]
`include "itb_cfg.svh"

`default_nettype none

module itb_timer_properties
    import itb_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        subclock,
    input wire itb_pwr_t    power_mode,
    input wire logic        clock_output_pin,
    input wire logic        overflow_irq
);

    timeunit 1ns;
    timeprecision 1ps;

    logic wr;
    logic outen_r;
    logic ien_r;
    logic raw_sel_r;
    logic m7_r;

    assign wr = psel && penable && pwrite;

    // Shadows of four writable bits (OUTEN, IEN, source select, mode bit 7), updated at the same edge as the block.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            outen_r <= 1'b0;
            ien_r   <= 1'b0;
            raw_sel_r <= 1'b0;
            m7_r    <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == `ITB_OFS_CTRL)
            begin
                outen_r <= pwdata[`ITB_CTRL_OUTEN];
                ien_r   <= pwdata[`ITB_CTRL_IEN];
            end
            if (paddr == `ITB_OFS_SRCSEL)
                raw_sel_r <= pwdata[0];
            if (paddr == `ITB_OFS_MODE)
                m7_r <= pwdata[`ITB_MODE_OUT_MSB];
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence s_rd(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    // The pin lags the subclock by the synchroniser and the output flop.
    sequence s_raw_steady;
        (raw_sel_r && outen_r && $stable(subclock))[*6];
    endsequence

    a_select_ones:
        assert property (s_rd(`ITB_OFS_SRCSEL) |=> prdata[7:1] == 7'h7F)
        else $error("Select register reserved bits not one.");
    a_mode_bit_four:
        assert property (s_rd(`ITB_OFS_MODE) |=> prdata[4])
        else $error("Mode register bit four not one.");
    a_count_hidden:
        assert property (s_rd(`ITB_OFS_COUNT) ##0 power_mode == ITB_SUBACTIVE
            |=> prdata[7:0] == 8'h00) else $error("Count readable asleep.");
    a_reset_quiet:
        assert property ($fell(srst) |-> !overflow_irq && !clock_output_pin)
        else $error("Outputs active after reset.");
    a_irq_needs_en:
        assert property (overflow_irq |-> ien_r)
        else $error("Interrupt without enable.");
    a_flag_sticks:
        assert property (overflow_irq && !(wr && paddr == `ITB_OFS_CTRL)
            |=> overflow_irq) else $error("Overflow request dropped.");
    a_pin_gated:
        assert property ((!outen_r)[*2] |-> !clock_output_pin)
        else $error("Clock pin active while disabled.");
    a_sys_div_halts:
        assert property ((!raw_sel_r && !m7_r
            && !(power_mode inside {ITB_ACTIVE, ITB_SLEEP}))[*2]
            |-> !clock_output_pin) else $error("System clock out asleep.");
    a_raw_subclock:
        assert property (s_raw_steady |-> clock_output_pin == subclock)
        else $error("Pin does not follow subclock.");

endmodule // itb_timer_properties

////////////////////////////////////////////////////////////////////////////
bind itb_timer itb_timer_properties itb_timer_properties_i (
    .sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .subclock, .power_mode, .clock_output_pin, .overflow_irq
);

`default_nettype wire

// [test/itb_timer_test.sv]
`include "itb_cfg.svh"

`default_nettype none

module itb_timer_test
    import itb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk     = 1'b0;
    logic        srst        = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic        subclock    = 1'b0;
    itb_pwr_t    power_mode  = ITB_ACTIVE;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clock_output_pin;
    logic        overflow_irq;
    logic [31:0] rd;
    logic        err;
    int          cyc         = 0;
    int          miscompares = 0;
    int          n_compared  = 0;

    itb_timer itb_timer_i (
        .sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .subclock, .power_mode,
        .clock_output_pin, .overflow_irq
    );

    always #2.5 sys_clk = ~sys_clk;

    // Subclock of 16 cycles; the ceiling sits well above the planned run.
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc[2:0] == 3'h7)
            subclock <= ~subclock;
        if (cyc == 40000)
        begin
            miscompares++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Slack of one edge: the window is not phase locked to the divider.
    task automatic rises(input int e);
        logic p;
        int n;
        repeat (16) @(posedge sys_clk);
        p = clock_output_pin;
        n = 0;
        repeat (1024)
        begin
            @(posedge sys_clk);
            n += (clock_output_pin && !p);
            p = clock_output_pin;
        end
        check(n >= e - 1 && n <= e + 1, 1'b1);
    endtask

    task automatic t_regs();
        rdc(`ITB_OFS_MODE, 32'h10);
        rdc(`ITB_OFS_SRCSEL, 32'hFE);
        rdc(`ITB_OFS_CTRL, 32'h01);
        rdc(`ITB_OFS_COUNT, 32'h00);
        wr(`ITB_OFS_SRCSEL, 32'h01);
        rdc(`ITB_OFS_SRCSEL, 32'hFF);
        wr(`ITB_OFS_SRCSEL, 32'h00);
        rdc(`ITB_OFS_SRCSEL, 32'hFE);
        wr(`ITB_OFS_MODE, 32'h00);
        rdc(`ITB_OFS_MODE, 32'h10);
        wr(`ITB_OFS_COUNT, 32'h55);
        rdc(`ITB_OFS_COUNT, 32'h00);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);
    endtask

    task automatic t_irq();
        int t1;
        wr(`ITB_OFS_CTRL, 32'h05);
        wr(`ITB_OFS_MODE, 32'h06);
        while (overflow_irq !== 1'b1) @(posedge sys_clk);
        t1 = cyc;
        rdc(`ITB_OFS_COUNT, 32'h00);
        rdc(`ITB_OFS_CTRL, 32'h0D);
        wr(`ITB_OFS_CTRL, 32'h0D);
        rdc(`ITB_OFS_CTRL, 32'h05);
        while (overflow_irq !== 1'b1) @(posedge sys_clk);
        check(cyc - t1, 8192);
        wr(`ITB_OFS_CTRL, 32'h01);
        rdc(`ITB_OFS_CTRL, 32'h09);
        check(overflow_irq, 1'b0);
    endtask

    task automatic t_halt();
        logic [31:0] c;
        power_mode <= ITB_WATCH;
        apb(1'b0, `ITB_OFS_COUNT, 32'h0);
        c = rd;
        repeat (200) @(posedge sys_clk);
        rdc(`ITB_OFS_COUNT, c);
        power_mode <= ITB_ACTIVE;
        repeat (200) @(posedge sys_clk);
        apb(1'b0, `ITB_OFS_COUNT, 32'h0);
        check(rd !== c, 1'b1);
    endtask

    task automatic t_base();
        wr(`ITB_OFS_CTRL, 32'h00);
        wr(`ITB_OFS_MODE, 32'h0B);
        rdc(`ITB_OFS_MODE, 32'h13);
        wr(`ITB_OFS_CTRL, 32'h01);
        wr(`ITB_OFS_MODE, 32'h0F);
        rdc(`ITB_OFS_MODE, 32'h1F);
        repeat (300) @(posedge sys_clk);
        rdc(`ITB_OFS_COUNT, 32'h00);
        power_mode <= ITB_WATCH;
        wr(`ITB_OFS_MODE, 32'h0B);
        repeat (640) @(posedge sys_clk);
        apb(1'b0, `ITB_OFS_COUNT, 32'h0);
        check(rd >= 9 && rd <= 11, 1'b1);
        power_mode <= ITB_SUBACTIVE;
        rdc(`ITB_OFS_COUNT, 32'h00);
        power_mode <= ITB_ACTIVE;
    endtask

    task automatic t_out();
        wr(`ITB_OFS_CTRL, 32'h03);
        for (int i = 0; i < 9; i++)
        begin
            wr(`ITB_OFS_SRCSEL, i / 8);
            wr(`ITB_OFS_MODE, (i % 8) << 5);
            rises(i < 4 ? 32 << i : i < 8 ? 2 << (i - 4) : 64);
        end
        wr(`ITB_OFS_CTRL, 32'h01);
        rises(0);
        wr(`ITB_OFS_CTRL, 32'h03);
        wr(`ITB_OFS_SRCSEL, 32'h00);
        wr(`ITB_OFS_MODE, 32'h60);
        power_mode <= ITB_STANDBY;
        rises(0);
        power_mode <= ITB_WATCH;
        wr(`ITB_OFS_MODE, 32'hE0);
        rises(16);
        power_mode <= ITB_ACTIVE;
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        t_regs();
        t_irq();
        t_halt();
        t_base();
        t_out();
        conclude();
    end

endmodule // itb_timer_test

`default_nettype wire
